// [design/dhpc_pkg.sv]
// Purpose: Shared constants and types for the DMA handshake pin control block
// Assumes: One clock (core_clk, 40 MHz), synchronous active-low reset
// Notes:   Configuration arrives as plain inputs; no software-visible registers
//
// How it works
// - The end-of-transfer pin is an input whose active level is chosen by a polarity setting.
// - The end-of-transfer input is acted on only in target operation and is ignored as initiator.
// - The request line carries a programmable polarity whether it is driven or sampled.
// - The request line direction follows the initiator-select configuration bit.
// - With initiator-select at 1 the block samples the request line as an input.
// - With initiator-select at 0 the block drives the request line toward the far controller.
package dhpc_pkg;

  // Configuration bits that steer the pin logic
  typedef struct packed {
    logic initiator_sel;        // 1: initiator, request is an input
    logic request_active_high;  // 1: request asserted when line is high
    logic end_active_high;      // 1: end-of-transfer asserted when pin is high
  } dhpc_cfg_s;

  // Synchronised pin bundle, one bit per sampled pin
  typedef struct packed {
    logic request;
    logic transfer_end;
  } dhpc_pins_s;

  localparam int unsigned DHPC_SYNC_STAGES = 3;
  localparam int unsigned DHPC_PIN_COUNT   = 2;
  localparam int unsigned DHPC_PIN_REQ     = 1;  // Bit position in dhpc_pins_s
  localparam int unsigned DHPC_PIN_END     = 0;

  // Values after reset
  localparam logic DHPC_RST_OE      = 1'h0;  // Driver released during reset
  localparam logic DHPC_RST_LEVEL   = 1'h0;
  localparam logic DHPC_RST_SYNC    = 1'h0;

endpackage : dhpc_pkg

// [design/dhpc_pin_sync.sv]
// Purpose: Three-stage pin synchroniser with agreement filter, one lane per pin
// Assumes: Pins are asynchronous to core_clk
// Notes:   Output moves only when the second and third stages agree
`timescale 1ns/1ps
module dhpc_pin_sync #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_sync
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      logic stage1;
      logic stage2;
      logic stage3;

      // Capture chain; stage1 is read only by stage2
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          stage1 <= dhpc_pkg::DHPC_RST_SYNC;
          stage2 <= dhpc_pkg::DHPC_RST_SYNC;
          stage3 <= dhpc_pkg::DHPC_RST_SYNC;
        end else begin
          stage1 <= pin_async[g];
          stage2 <= stage1;
          stage3 <= stage2;
        end
      end

      // Accept a new level once two stages agree
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          pin_sync[g] <= dhpc_pkg::DHPC_RST_SYNC;
        end else if (stage2 == stage3) begin
          pin_sync[g] <= stage3;
        end
      end
    end
  endgenerate

endmodule : dhpc_pin_sync

// [design/dhpc_top.sv]
// Purpose: Request and end-of-transfer pin control for the DMA handshake
// Assumes: Configuration and request_drive come from logic on core_clk
// Notes:   Request pin is split into in, out and output enable
`timescale 1ns/1ps
module dhpc_top (
  input  wire logic                core_clk,
  input  wire logic                reset_n,
  // Configuration
  input  wire dhpc_pkg::dhpc_cfg_s cfg,
  // Transfer engine side
  input  wire logic                request_drive,
  output logic                     request_seen,
  output logic                     transfer_end,
  output logic                     transfer_end_pulse,
  output logic                     initiator_active,
  // Pins
  input  wire logic                dma_request_line_in,
  output logic                     dma_request_line_out,
  output logic                     dma_request_line_oe,
  input  wire logic                transfer_end_in
);

  dhpc_pkg::dhpc_pins_s pins_async;
  dhpc_pkg::dhpc_pins_s pins_sync;
  logic                 next_request_seen;
  logic                 next_transfer_end;
  logic                 next_request_out;

  // Bundle the asynchronous pins for synchronisation
  assign pins_async.request      = dma_request_line_in;
  assign pins_async.transfer_end = transfer_end_in;

  // Both input pins cross into core_clk through the filter
  dhpc_pin_sync #(
    .WIDTH     (dhpc_pkg::DHPC_PIN_COUNT)
  ) u_sync (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .pin_async (pins_async),
    .pin_sync  (pins_sync)
  );

  // Polarity correction of sampled and driven levels
  always_comb begin
    next_request_seen = 1'h0;
    next_transfer_end = 1'h0;
    next_request_out  = 1'h0;
    if (cfg.initiator_sel) begin
      next_request_seen = ~(pins_sync.request ^ cfg.request_active_high);
    end else begin
      next_transfer_end = ~(pins_sync.transfer_end ^ cfg.end_active_high);
    end
    next_request_out = ~(request_drive ^ cfg.request_active_high);
  end

  // Direction of the request pin
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      dma_request_line_oe <= dhpc_pkg::DHPC_RST_OE;
    end else begin
      dma_request_line_oe <= ~cfg.initiator_sel;
    end
  end

  // Level driven onto the request pin
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      dma_request_line_out <= dhpc_pkg::DHPC_RST_LEVEL;
    end else begin
      dma_request_line_out <= next_request_out;
    end
  end

  // Request seen from the far party in initiator operation
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      request_seen <= dhpc_pkg::DHPC_RST_LEVEL;
    end else begin
      request_seen <= next_request_seen;
    end
  end

  // End-of-transfer level and its rising-edge pulse
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      transfer_end       <= dhpc_pkg::DHPC_RST_LEVEL;
      transfer_end_pulse <= dhpc_pkg::DHPC_RST_LEVEL;
    end else begin
      transfer_end       <= next_transfer_end;
      transfer_end_pulse <= next_transfer_end & ~transfer_end;
    end
  end

  // Mode flag for the transfer engine
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      initiator_active <= dhpc_pkg::DHPC_RST_LEVEL;
    end else begin
      initiator_active <= cfg.initiator_sel;
    end
  end

  // Checks on the pin control
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Mode held steady for two cycles
  sequence target_held_s;
    !cfg.initiator_sel [*2];
  endsequence

  sequence initiator_held_s;
    cfg.initiator_sel [*2];
  endsequence

  // Driver enabled one cycle after target is chosen
  target_drive_a : assert property (
    !cfg.initiator_sel |=> dma_request_line_oe)
    else $error("request driver not enabled in target mode");

  // Driver released one cycle after initiator is chosen
  driver_release_a : assert property (
    cfg.initiator_sel |=> !dma_request_line_oe && initiator_active)
    else $error("request driver still on in initiator mode");

  // Direction switch follows the bit with one cycle lag
  direction_follow_a : assert property (
    $changed(cfg.initiator_sel) |=> $changed(dma_request_line_oe))
    else $error("request direction did not follow select bit");

  // Driven level obeys polarity
  drive_polarity_a : assert property (
    target_held_s |=>
      dma_request_line_out == ~($past(request_drive) ^ $past(cfg.request_active_high)))
    else $error("driven request level has wrong polarity");

  // Sampled request obeys polarity in initiator mode
  sample_request_a : assert property (
    initiator_held_s |=>
      request_seen == ~($past(pins_sync.request) ^ $past(cfg.request_active_high)))
    else $error("sampled request wrong in initiator mode");

  // No request reported while target
  request_quiet_a : assert property (
    !cfg.initiator_sel |=> !request_seen)
    else $error("request reported in target mode");

  // End-of-transfer ignored as initiator
  end_ignored_a : assert property (
    cfg.initiator_sel |=> !transfer_end && !transfer_end_pulse)
    else $error("end-of-transfer acted on in initiator mode");

  // End-of-transfer level obeys polarity as target
  end_polarity_a : assert property (
    !cfg.initiator_sel |=>
      transfer_end == ~($past(pins_sync.transfer_end) ^ $past(cfg.end_active_high)))
    else $error("end-of-transfer level has wrong polarity");

  // Pulse appears only on the first cycle of the level
  end_pulse_a : assert property (
    transfer_end_pulse |-> transfer_end && !$past(transfer_end))
    else $error("end-of-transfer pulse not on rising level");

  // Rise of the end pin reaches the filtered level within four cycles
  sync_latency_a : assert property (
    $rose(transfer_end_in) ##1 transfer_end_in [*4] |-> pins_sync.transfer_end)
    else $error("end pin not synchronised within four cycles");

endmodule : dhpc_top

// [dv/dhpc_far_model.sv]
// Purpose: External DMA controller seen from the request pin
// Assumes: Bench says whether the far party wants to request
// Notes:   Drives only while the block has released the pin
`timescale 1ns/1ps
module dhpc_far_model (
  input  wire logic core_clk,
  input  wire logic dut_oe,
  input  wire logic want_req,
  input  wire logic req_active_high,
  output logic      far_oe,
  output logic      far_out
);
  // Take the pin only when the block lets go of it
  assign far_oe  = ~dut_oe;
  // Present the request at the agreed polarity
  assign far_out = ~(want_req ^ req_active_high);
endmodule : dhpc_far_model

// [dv/dhpc_top_tb_top.sv]
// Purpose: Self-checking bench for the handshake pin control
// Assumes: Pin has a pull-down when nobody drives it
// Notes:   Random config and pins, seed 32, plus corner cases
`timescale 1ns/1ps
module dhpc_top_tb_top;
  logic                core_clk = 1'h0;
  logic                reset_n = 1'h0;
  logic                request_drive = 1'h0;
  logic                want_req = 1'h0;
  logic                end_pin = 1'h0;
  dhpc_pkg::dhpc_cfg_s cfg = '0;
  logic                req_seen, t_end, t_pulse, init_act;
  logic                l_out, l_oe, far_oe, far_out, line;
  int                  n_fail = 0;
  int                  compares = 0;
  // Resolve the shared request pin
  assign line = l_oe ? l_out : (far_oe ? far_out : 1'h0);
  dhpc_top dut (.core_clk(core_clk), .reset_n(reset_n), .cfg(cfg),
    .request_drive(request_drive), .request_seen(req_seen), .transfer_end(t_end),
    .transfer_end_pulse(t_pulse), .initiator_active(init_act),
    .dma_request_line_in(line), .dma_request_line_out(l_out),
    .dma_request_line_oe(l_oe), .transfer_end_in(end_pin));
  dhpc_far_model far (.core_clk(core_clk), .dut_oe(l_oe), .want_req(want_req),
    .req_active_high(cfg.request_active_high), .far_oe(far_oe), .far_out(far_out));
  always #12.5 core_clk = ~core_clk;
  task automatic check1(string name, logic exp, logic got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask : check1
  task automatic tally_and_finish;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // Expected pin level of the end input as seen by the block
  function automatic logic end_exp(logic pin, logic hi, logic ini);
    return ~ini & ~(pin ^ hi);
  endfunction : end_exp
  // Apply one setting, let the synchronisers settle, then compare
  task automatic apply(logic [2:0] c, logic rd, logic wr, logic ep);
    @(posedge core_clk);
    cfg <= c;
    request_drive <= rd;
    want_req <= wr;
    end_pin <= ep;
    repeat (7) @(posedge core_clk);
    #1;
    check1("oe", ~c[2], l_oe);
    check1("mode", c[2], init_act);
    if (!c[2]) check1("line", ~(rd ^ c[1]), line);
    check1("seen", c[2] & wr, req_seen);
    check1("end", end_exp(ep, c[0], c[2]), t_end);
    check1("pulse", 1'h0, t_pulse);
  endtask : apply
  // Count end pulses after the pin becomes asserted
  task automatic pulse_case(logic [2:0] c, logic [1:0] n);
    logic [1:0] cnt;
    cnt = 2'h0;
    apply(c, 1'h0, 1'h0, ~c[0]);
    @(posedge core_clk);
    end_pin <= c[0];
    repeat (8) begin
      @(posedge core_clk);
      #1;
      cnt += {1'h0, t_pulse};
    end
    check1("pulse_count", n == cnt, 1'h1);
  endtask : pulse_case
  // Reset in mid-run with a driving target setting; the pin driver must let go
  task automatic reset_case;
    @(posedge core_clk);
    reset_n <= 1'h0;
    cfg <= 3'h2;
    request_drive <= 1'h1;
    repeat (2) @(posedge core_clk);
    #1;
    check1("mid_reset_oe", 1'h0, l_oe);
    check1("mid_reset_out", 1'h0, l_out);
    @(posedge core_clk);
    reset_n <= 1'h1;
  endtask : reset_case
  initial begin
    void'($urandom(32));
    repeat (4) @(posedge core_clk);
    reset_n <= 1'h1;
    #1;
    check1("reset_oe", 1'h0, l_oe);
    for (int i = 0; i < 16; i++) apply(i[2:0], i[3], ~i[3], i[0]);
    pulse_case(3'h1, 2'h1);
    pulse_case(3'h0, 2'h1);
    pulse_case(3'h5, 2'h0);
    reset_case();
    apply(3'h2, 1'h1, 1'h0, 1'h0);
    for (int i = 0; i < 60; i++) apply(3'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
    tally_and_finish();
  end
  // Watchdog well beyond the expected run
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
endmodule : dhpc_top_tb_top
